/* verilog/fdc_result_map.vh */
// result-status field positions, constant bits and reset values
// assumes inclusion by the floppy result/reset block files
`ifndef FDC_RESULT_MAP_VH
`define FDC_RESULT_MAP_VH
// result byte one bit positions
`define ST1_END_TRACK 7
`define ST1_CRC_FAULT 5
`define ST1_SERVICE_LATE 4
`define ST1_SECTOR_MISSING 2
`define ST1_WRITE_REFUSED 1
`define ST1_ID_LOST 0
// result byte two bit positions
`define ST2_DELETED_MARK 6
`define ST2_PAYLOAD_CRC 5
`define ST2_TRACK_MISMATCH 4
`define ST2_BAD_TRACK 1
`define ST2_DATA_MARK_ABSENT 0
// result byte three bit positions
`define ST3_WRITE_PROTECT 6
`define ST3_ONE_HI 5
`define ST3_OUTER_TRACK 4
`define ST3_ONE_LO 3
`define ST3_HEAD 2
// values
`define BAD_TRACK_NUMBER 8'hff
`define RATE_250K 2'h2
`define ST_CLEAR 8'h00
// result phase byte selection
`define SEL_ST1 2'h1
`define SEL_ST2 2'h2
`define SEL_ST3 2'h3
`endif

/* verilog/reset_control.v */
// reset control: combines pin, power-on, held and self-clearing resets
// assumes all inputs synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "fdc_result_map.vh"
module reset_control (
  input wire clock,
  input wire rst_n,
  input wire power_on_reset,
  input wire dor_reset_write,
  input wire dor_reset_value,
  input wire dsr_reset_write,
  output reg hold_reset,
  output wire core_reset,
  output wire hard_reset
);
  reg dsr_pulse;

  // ==========================================================
  // hard reset sources
  assign hard_reset = ~rst_n | power_on_reset;

  // held reset bit and self-clearing pulse
  always @(posedge clock) begin
    if (hard_reset) begin
      hold_reset <= 1'b1;
      dsr_pulse <= 1'b0;
    end else begin
      if (dor_reset_write)
        hold_reset <= dor_reset_value;
      dsr_pulse <= dsr_reset_write;
    end
  end

  // held reset dominates; pulse only adds a cycle
  assign core_reset = hard_reset | hold_reset | dsr_pulse;
endmodule
`default_nettype wire

/* verilog/status_select.v */
// result byte multiplexer for the data register
// assumes selection code from the command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fdc_result_map.vh"
module status_select (
  input wire [1:0] select,
  input wire [7:0] st1,
  input wire [7:0] st2,
  input wire [7:0] st3,
  output reg [7:0] byte_out
);
  // ==========================================================
  // choose the result byte
  always @* begin
    case (select)
      `SEL_ST1: byte_out = st1;
      `SEL_ST2: byte_out = st2;
      `SEL_ST3: byte_out = st3;
      default: byte_out = `ST_CLEAR;
    endcase
  end
endmodule
`default_nettype wire

/* verilog/floppy_result_status_and_reset.v */
// floppy controller result status bytes and reset control
// assumes events are single-cycle pulses from the command sequencer,
// pins synchronous to clock, host reads via data register in result phase
// How it works
// - past-last-sector or read/write terminal count sets bit 7
// - unused status bits read zero
// - byte three bits 5, 3 read one
// - id or data crc error sets bit 5
// - late service sets overrun bit 4
// - missing sector in a read, bad id, sequence sets bit 2
// - write protect during write sets bit 1
// - no id mark or data mark sets bit 0
// - wrong data mark type sets byte two bit 6
// - data field crc sets byte two bit 5
// - id track differs sets mismatch bit 4
// - differing track equal ff sets bit 1
// - no data mark sets byte two bit 0
// - byte three shows live pin levels
// - pin, power-on, two soft resets, exit powerdown
// - any reset aborts and goes idle
// - reset clears configure, enables polling
// - pin reset spares specify, sets held reset
// - both soft resets reset core identically
// - rate reset self-clears, held reset stays
// - held reset wins over self-clearing reset
// - bytes read through data register in result
// - rate bits kept on soft, 250k on hard
`timescale 1ns/1ps
`default_nettype none
`include "fdc_result_map.vh"
module floppy_result_status_and_reset (
  input wire clock,
  input wire rst_n,
  input wire power_on_reset,
  // host register writes
  input wire dor_reset_write,
  input wire dor_reset_value,
  input wire dsr_write,
  input wire dsr_reset_bit,
  input wire [1:0] dsr_rate,
  input wire configure_write,
  input wire configure_poll_disable,
  input wire specify_write,
  input wire [7:0] specify_value,
  // result phase read
  input wire result_read,
  input wire [1:0] result_select,
  // command sequencer events
  input wire command_start,
  input wire read_data_cmd,
  input wire read_deleted_cmd,
  input wire write_cmd,
  input wire beyond_last_sector,
  input wire transfer_final,
  input wire id_crc_error,
  input wire data_crc_error,
  input wire service_late,
  input wire sector_not_found,
  input wire read_id_error,
  input wire track_sequence_error,
  input wire id_mark_timeout,
  input wire data_mark_missing,
  input wire deleted_mark_found,
  input wire normal_mark_found,
  input wire id_track_valid,
  input wire [7:0] id_track,
  input wire [7:0] current_track,
  input wire power_down_request,
  // drive pins
  input wire write_protect_input,
  input wire outer_track_sense,
  input wire head_line,
  input wire [1:0] drive_select_outputs,
  // outputs
  output reg [7:0] data_out,
  output wire [7:0] result_status_one,
  output wire [7:0] result_status_two,
  output wire [7:0] drive_pin_status,
  output reg [1:0] rate_select,
  output reg [7:0] specify_hold,
  output reg polling_enable,
  output reg power_down,
  output wire core_reset,
  output wire controller_idle,
  output wire reset_held
);
  wire hard_reset;
  wire hold_reset;
  wire [7:0] mux_byte;
  reg end_track, crc_fault_flag, service_late_flag, sector_missing_flag;
  reg write_refused_flag, id_field_lost_flag;
  reg deleted_mark_seen, payload_crc_flag, track_mismatch_flag;
  reg bad_track_flag, data_mark_absent;
  wire track_differs;

  // ==========================================================
  // reset sources
  reset_control u_reset (
    .clock(clock),
    .rst_n(rst_n),
    .power_on_reset(power_on_reset),
    .dor_reset_write(dor_reset_write),
    .dor_reset_value(dor_reset_value),
    .dsr_reset_write(dsr_write & dsr_reset_bit),
    .hold_reset(hold_reset),
    .core_reset(core_reset),
    .hard_reset(hard_reset)
  );
  assign reset_held = hold_reset;
  assign controller_idle = core_reset;

  // ==========================================================
  // rate select, specify values, configure state
  always @(posedge clock) begin
    if (hard_reset)
      rate_select <= `RATE_250K;
    else if (dsr_write)
      rate_select <= dsr_rate;
  end

  // specify settings survive every reset
  always @(posedge clock) begin
    if (specify_write)
      specify_hold <= specify_value;
  end

  // configure state returns to polling on any reset
  always @(posedge clock) begin
    if (core_reset)
      polling_enable <= 1'b1;
    else if (configure_write)
      polling_enable <= ~configure_poll_disable;
  end

  // power down left on any reset
  always @(posedge clock) begin
    if (core_reset)
      power_down <= 1'b0;
    else if (power_down_request)
      power_down <= 1'b1;
  end

  // ==========================================================
  // error flags: cleared at command start, events win over clear
  assign track_differs = id_track_valid & (id_track != current_track);
  always @(posedge clock) begin
    if (core_reset) begin
      end_track <= 1'b0;
      crc_fault_flag <= 1'b0;
      service_late_flag <= 1'b0;
      sector_missing_flag <= 1'b0;
      write_refused_flag <= 1'b0;
      id_field_lost_flag <= 1'b0;
      deleted_mark_seen <= 1'b0;
      payload_crc_flag <= 1'b0;
      track_mismatch_flag <= 1'b0;
      bad_track_flag <= 1'b0;
      data_mark_absent <= 1'b0;
    end else begin
      end_track <= (end_track & ~command_start) | beyond_last_sector
        | (transfer_final & (read_data_cmd | read_deleted_cmd | write_cmd));
      crc_fault_flag <= (crc_fault_flag & ~command_start)
        | id_crc_error | data_crc_error;
      service_late_flag <= (service_late_flag & ~command_start) | service_late;
      sector_missing_flag <= (sector_missing_flag & ~command_start)
        | ((read_data_cmd | read_deleted_cmd) & sector_not_found)
        | read_id_error | track_sequence_error;
      write_refused_flag <= (write_refused_flag & ~command_start)
        | (write_cmd & write_protect_input);
      id_field_lost_flag <= (id_field_lost_flag & ~command_start)
        | id_mark_timeout | data_mark_missing;
      deleted_mark_seen <= (deleted_mark_seen & ~command_start)
        | (read_data_cmd & deleted_mark_found)
        | (read_deleted_cmd & normal_mark_found);
      payload_crc_flag <= (payload_crc_flag & ~command_start) | data_crc_error;
      track_mismatch_flag <= (track_mismatch_flag & ~command_start)
        | track_differs;
      bad_track_flag <= (bad_track_flag & ~command_start)
        | (track_differs & (id_track == `BAD_TRACK_NUMBER));
      data_mark_absent <= (data_mark_absent & ~command_start)
        | data_mark_missing;
    end
  end

  // ==========================================================
  // byte assembly with fixed bits
  assign result_status_one = {end_track, 1'b0, crc_fault_flag, service_late_flag,
    1'b0, sector_missing_flag, write_refused_flag, id_field_lost_flag};
  assign result_status_two = {1'b0, deleted_mark_seen, payload_crc_flag,
    track_mismatch_flag, 2'b00, bad_track_flag, data_mark_absent};
  assign drive_pin_status = {1'b0, write_protect_input, 1'b1, outer_track_sense,
    1'b1, head_line, drive_select_outputs};

  status_select u_select (
    .select(result_select),
    .st1(result_status_one),
    .st2(result_status_two),
    .st3(drive_pin_status),
    .byte_out(mux_byte)
  );

  // data register output, loaded on result read
  always @(posedge clock) begin
    if (core_reset)
      data_out <= `ST_CLEAR;
    else if (result_read)
      data_out <= mux_byte;
  end
endmodule
`default_nettype wire

/* tb/drive_model.sv */
// drive side model: sensed pin levels of one drive
// assumes the bench hands over wanted levels before a rising edge
`timescale 1ns/1ps
`default_nettype none
module drive_model (
  input wire logic clock,
  input wire logic [4:0] want,
  output wire logic write_protect_input,
  output wire logic outer_track_sense,
  output wire logic head_line,
  output wire logic [1:0] drive_select_outputs
);
  // ==========
  // pin levels
  logic [4:0] lv = 5'h00;
  // pins follow the wanted levels one edge later
  always @(posedge clock) begin
    lv <= want;
  end
  assign {write_protect_input, outer_track_sense, head_line, drive_select_outputs} = lv;
endmodule
`default_nettype wire

/* tb/fdc_result_props.sv */
// checker: result byte and reset relations at the block's ports
// assumes binding to the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fdc_result_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic power_on_reset,
  input wire logic dor_reset_write,
  input wire logic dsr_write,
  input wire logic dsr_reset_bit,
  input wire logic result_read,
  input wire logic [1:0] result_select,
  input wire logic data_crc_error,
  input wire logic service_late,
  input wire logic [7:0] data_out,
  input wire logic [7:0] result_status_one,
  input wire logic [7:0] result_status_two,
  input wire logic [7:0] drive_pin_status,
  input wire logic [1:0] rate_select,
  input wire logic polling_enable,
  input wire logic power_down,
  input wire logic core_reset,
  input wire logic controller_idle,
  input wire logic reset_held
);
  // ==========
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_fixed_bits: assert property ((result_status_one & 8'h48) == 8'h00 &&
    (result_status_two & 8'h8c) == 8'h00 && (drive_pin_status & 8'ha8) == 8'h28)
    else $error("fixed bits wrong");
  a_crc_sets: assert property (data_crc_error && !core_reset |=>
    result_status_one[5] && result_status_two[5]) else $error("crc flags not set");
  a_late_sets: assert property (service_late && !core_reset |=>
    result_status_one[4]) else $error("late flag not set");
  a_reset_clears: assert property (core_reset |=> result_status_one == 8'h00 &&
    result_status_two == 8'h00 && !power_down && polling_enable) else $error("reset state");
  a_power_on: assert property (power_on_reset |=>
    reset_held && core_reset && rate_select == 2'h2) else $error("power-on reset");
  a_held_stays: assert property (reset_held && !dor_reset_write |=>
    reset_held) else $error("held reset lost");
  a_held_wins: assert property (reset_held && dsr_write && dsr_reset_bit && !dor_reset_write |=>
    core_reset && controller_idle ##1 (core_reset || $past(dor_reset_write)))
    else $error("held reset not active");
  a_self_clear: assert property (dsr_write && dsr_reset_bit && !reset_held &&
    !dor_reset_write && !power_on_reset |=> core_reset ##1 (!core_reset || reset_held
    || power_on_reset || $past(dsr_write && dsr_reset_bit))) else $error("self reset length");
  a_read_one: assert property (result_read && result_select == 2'h1 && !core_reset |=>
    data_out == $past(result_status_one)) else $error("data byte wrong");
endmodule
bind floppy_result_status_and_reset fdc_result_props chk_i (.*);
`default_nettype wire

/* tb/floppy_result_status_and_reset_test.sv */
// testbench: result bytes and reset sources
// assumes the design header is on the include path
`timescale 1ns/1ps
`default_nettype none
module floppy_result_status_and_reset_test;
  // ==========
  // signals
  logic clock = 0;
  logic rst_n = 0;
  logic power_on_reset, dor_reset_write, dor_reset_value, dsr_write, dsr_reset_bit;
  logic configure_write, configure_poll_disable, specify_write, result_read;
  logic command_start, read_data_cmd, read_deleted_cmd, write_cmd;
  logic id_track_valid, power_down_request, rd_d;
  logic [1:0] dsr_rate, result_select, r;
  logic [7:0] specify_value, id_track, current_track;
  logic [11:0] ev;
  logic [4:0] want;
  logic [15:0] tbl [12];
  logic [7:0] q [$];
  wire beyond_last_sector, transfer_final, id_crc_error, data_crc_error, service_late;
  wire sector_not_found, read_id_error, track_sequence_error, id_mark_timeout;
  wire data_mark_missing, deleted_mark_found, normal_mark_found;
  wire write_protect_input, outer_track_sense, head_line;
  wire polling_enable, power_down, core_reset, controller_idle, reset_held;
  wire [1:0] drive_select_outputs, rate_select;
  wire [7:0] data_out, result_status_one, result_status_two, drive_pin_status, specify_hold;
  int n_mismatch = 0;
  int n_tests = 0;
  integer seed = 29;
  int i;
  assign {beyond_last_sector, transfer_final, id_crc_error, data_crc_error, service_late,
    sector_not_found, read_id_error, track_sequence_error, id_mark_timeout,
    data_mark_missing, deleted_mark_found, normal_mark_found} = ev;
  floppy_result_status_and_reset uut (.*);
  drive_model drv (.*);
  always #4 clock = ~clock;
  // ==========
  // tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    n_tests++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] x);
    result_read = 1;
    result_select = s;
    q.push_back(x);
    @(negedge clock);
  endtask
  // one command: start, one event cycle, then read all bytes back
  task automatic run(input logic [11:0] e, input logic v, input logic [7:0] t,
    input logic [15:0] x);
    @(negedge clock);
    command_start = 1;
    @(negedge clock);
    command_start = 0;
    ev = e;
    id_track_valid = v;
    id_track = t;
    @(negedge clock);
    ev = 0;
    id_track_valid = 0;
    rd(2'h1, x[15:8]);
    rd(2'h2, x[7:0]);
    rd(2'h3, {1'b0, want[4], 1'b1, want[3], 1'b1, want[2:0]});
    rd(2'h0, 8'h00);
    result_read = 0;
  endtask
  task automatic drive_output_control(input logic v);
    dor_reset_write = 1;
    dor_reset_value = v;
    @(negedge clock);
    dor_reset_write = 0;
  endtask
  task automatic dsr;
    r = $random(seed);
    dsr_write = 1;
    dsr_reset_bit = 1;
    dsr_rate = r;
    @(negedge clock);
    dsr_write = 0;
  endtask
  // ==========
  // result monitor and watchdog
  always @(posedge clock) rd_d <= result_read && !core_reset;
  always @(negedge clock) if (rd_d) chk(data_out, q.pop_front());
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    test_done;
  end
  // ==========
  // main sequence
  initial begin
    {power_on_reset, dor_reset_write, dor_reset_value, dsr_write, dsr_reset_bit} = 0;
    {configure_write, configure_poll_disable, specify_write, result_read, command_start} = 0;
    {read_data_cmd, read_deleted_cmd, write_cmd, id_track_valid, power_down_request} = 0;
    {dsr_rate, result_select, specify_value, id_track, ev, want} = 0;
    current_track = 8'h7f & $random(seed);
    tbl = '{16'h0040, 16'h0040, 16'h0101, 16'h0100, 16'h0400, 16'h0400, 16'h0400,
      16'h1000, 16'h2020, 16'h2000, 16'h8000, 16'h8000};
    repeat (6) @(negedge clock);
    rst_n = 1;
    chk(reset_held, 1);
    chk(rate_select, 2'h2);
    drive_output_control(0);
    chk(core_reset, 0);
    for (i = 0; i < 12; i++) begin
      want = $random(seed);
      read_data_cmd = i != 0;
      read_deleted_cmd = i == 0;
      run(12'h001 << i, 0, 0, tbl[i]);
    end
    run(0, 1, current_track, 16'h0000);
    run(0, 1, current_track + 8'h01, 16'h0010);
    run(0, 1, 8'hff, 16'h0012);
    read_data_cmd = 0;
    write_cmd = 1;
    want = 0;
    run(0, 0, 0, 16'h0000);
    want = 5'h10;
    repeat (2) @(negedge clock);
    rd(2'h1, 8'h02);
    result_read = 0;
    // end the write command so the protect level cannot set flags later
    write_cmd = 0;
    $display("status bytes done");
    dsr;
    chk(core_reset, 1);
    @(negedge clock);
    chk(core_reset, 0);
    chk(result_status_one, 8'h00);
    chk(rate_select, r);
    drive_output_control(1);
    dsr;
    @(negedge clock);
    chk(core_reset, 1);
    chk(rate_select, r);
    drive_output_control(0);
    chk(core_reset, 0);
    power_down_request = 1;
    configure_write = 1;
    configure_poll_disable = 1;
    specify_write = 1;
    specify_value = $random(seed);
    @(negedge clock);
    {power_down_request, configure_write, specify_write} = 0;
    chk(power_down, 1);
    chk(polling_enable, 0);
    power_on_reset = 1;
    @(negedge clock);
    power_on_reset = 0;
    rst_n = 0;
    @(negedge clock);
    rst_n = 1;
    @(negedge clock);
    chk(power_down, 0);
    chk(polling_enable, 1);
    chk(specify_hold, specify_value);
    chk(controller_idle, 1);
    drive_output_control(0);
    run(12'h100, 0, 0, 16'h2020);
    // let the monitor take the last byte before the verdict
    repeat (2) @(negedge clock);
    $display("resets done");
    test_done;
  end
endmodule
`default_nettype wire
